// File: tmr_chan_pkg.sv
package tmr_chan_pkg;
   // Field positions of the channel mode low byte and of the overflow flag in the status byte.
   localparam int EDGE_HI_POS = 7;
   localparam int EDGE_LO_POS = 6;
   localparam int MODE_MSB_POS = 3;
   localparam int MODE_LSB_POS = 1;
   localparam int START_BHV_POS = 0;
   localparam int OVF_POS = 0;
   // Reset values.
   localparam logic [7:0] MODE_LOW_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Mask that keeps bits 4 and 5 of the mode byte at zero.
   localparam logic [7:0] MODE_LOW_WMASK = 8'hcf;
   // Edge select encodings.
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_LOW_W = 2'h2;
   localparam logic [1:0] EDGE_HIGH_W = 2'h3;
   // Operation mode encodings of mode bits 3..1.
   localparam logic [2:0] MODE_INTERVAL = 3'h0;
   localparam logic [2:0] MODE_CAPTURE = 3'h2;
   localparam logic [2:0] MODE_EVENT = 3'h3;
   localparam logic [2:0] MODE_ONE_COUNT = 3'h4;
   localparam logic [2:0] MODE_CAP_ONE = 3'h6;
   // Counter width default.
   localparam int CNT_WIDTH = 16;
   // Count run states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_WAIT = 2'b11
   } run_state_t;
endpackage

// File: tmr_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_edge_sync
   import tmr_chan_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic rise_pulse,
   output logic fall_pulse
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } sync_state_t;

   sync_state_t cur_ff;
   sync_state_t nxt_st;

   // Three stages; a change counts once stages two and three agree.
   always_comb begin
      nxt_st = cur_ff;
      nxt_st.s1 = pin_in;
      nxt_st.s2 = cur_ff.s1;
      nxt_st.s3 = cur_ff.s2;
      if (cur_ff.s2 == cur_ff.s3) begin
         nxt_st.level = cur_ff.s3;
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   // Edge pulses come from the filtered level.
   assign rise_pulse = (cur_ff.s2 == cur_ff.s3) && cur_ff.s3 && !cur_ff.level;
   assign fall_pulse = (cur_ff.s2 == cur_ff.s3) && !cur_ff.s3 && cur_ff.level;
endmodule
`default_nettype wire

// File: tmr_chan_mode.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_chan_mode
   import tmr_chan_pkg::*;
#(
   parameter int WIDTH = CNT_WIDTH
)(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic channel_timer_input,
   input wire logic count_enable,
   input wire logic count_stop,
   input wire logic software_start_trigger,
   input wire logic [WIDTH-1:0] reload_value,
   input wire logic mode_wr,
   input wire logic [7:0] mode_wdata,
   input wire logic status_rd,
   input wire logic status_rd_byte,
   output logic [7:0] channel_mode_low_byte,
   output logic [7:0] channel_overflow_status,
   output logic [7:0] status_rdata,
   output logic status_rd_err,
   output logic [WIDTH-1:0] channel_counter,
   output logic [WIDTH-1:0] capture_value,
   output logic count_up,
   output logic channel_interrupt,
   output logic channel_timer_output,
   output logic mode_illegal
);
   // Elaboration refuses counter widths that the logic cannot serve.
   if (WIDTH < 2 || WIDTH > 32) begin : g_width_check
      $error("WIDTH must lie between 2 and 32");
   end

   typedef struct packed {
      logic [7:0] mode;
      logic ovf;
      logic wrapped;
      run_state_t run;
      logic [WIDTH-1:0] cnt;
      logic [WIDTH-1:0] cap;
      logic irq;
      logic tout;
      logic [7:0] rdata;
      logic rd_err;
   } chan_state_t;

   chan_state_t cur_ff;
   chan_state_t nxt_st;

   logic rise_p;
   logic fall_p;
   logic [1:0] edge_sel;
   logic [2:0] op_mode;
   logic start_bhv;
   logic valid_edge;
   logic start_edge;
   logic capture_edge;
   logic is_capture_mode;
   logic is_one_shot;
   logic counting;
   logic at_limit;
   logic start_ev;
   logic retrig_ok;

   // Synchronised edge pulses from the input pin.
   tmr_edge_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in(channel_timer_input),
      .rise_pulse(rise_p),
      .fall_pulse(fall_p)
   );

   // Returns one for the up-counting capture modes.
   function automatic logic mode_counts_up(input logic [2:0] m);
      return (m == MODE_CAPTURE) || (m == MODE_CAP_ONE);
   endfunction

   // Returns one for the five defined modes.
   function automatic logic mode_legal(input logic [2:0] m);
      return (m == MODE_INTERVAL) || (m == MODE_CAPTURE) ||
         (m == MODE_EVENT) || (m == MODE_ONE_COUNT) || (m == MODE_CAP_ONE);
   endfunction

   // Field decode.
   assign edge_sel = cur_ff.mode[EDGE_HI_POS:EDGE_LO_POS];
   assign op_mode = cur_ff.mode[MODE_MSB_POS:MODE_LSB_POS];
   assign start_bhv = cur_ff.mode[START_BHV_POS];
   assign is_capture_mode = mode_counts_up(op_mode);
   assign is_one_shot = (op_mode == MODE_ONE_COUNT) ||
      (op_mode == MODE_CAP_ONE);
   assign counting = (cur_ff.run == ST_RUN);

   // Edge selection for single-edge and width-measure settings.
   always_comb begin
      valid_edge = 1'b0;
      start_edge = 1'b0;
      capture_edge = 1'b0;
      unique case (edge_sel)
         EDGE_FALL: begin
            valid_edge = fall_p;
            start_edge = fall_p;
            capture_edge = fall_p;
         end
         EDGE_RISE: begin
            valid_edge = rise_p;
            start_edge = rise_p;
            capture_edge = rise_p;
         end
         EDGE_LOW_W: begin
            valid_edge = fall_p | rise_p;
            start_edge = fall_p;
            capture_edge = rise_p;
         end
         EDGE_HIGH_W: begin
            valid_edge = fall_p | rise_p;
            start_edge = rise_p;
            capture_edge = fall_p;
         end
      endcase
   end

   // Start trigger from the pin or software; one-shot restart rules.
   assign retrig_ok = !is_one_shot || !counting ||
      ((op_mode == MODE_ONE_COUNT) && start_bhv);
   assign start_ev = software_start_trigger ||
      (is_one_shot && start_edge && retrig_ok);
   assign at_limit = count_up ? (&cur_ff.cnt) : (cur_ff.cnt == '0);

   // Next-state logic for counting, capture, flag and register access.
   always_comb begin
      nxt_st = cur_ff;
      nxt_st.irq = 1'b0;
      nxt_st.rd_err = 1'b0;
      if (mode_wr) begin
         nxt_st.mode = mode_wdata & MODE_LOW_WMASK;
      end
      if (count_stop || !count_enable) begin
         nxt_st.run = ST_IDLE;
      end else if (start_ev) begin
         // Restart loads the counter; start interrupt only if fresh.
         nxt_st.run = ST_RUN;
         nxt_st.wrapped = 1'b0;
         nxt_st.cnt = is_capture_mode ? '0 : reload_value;
         if (!counting && !software_start_trigger && start_bhv &&
             (op_mode == MODE_INTERVAL || op_mode == MODE_CAPTURE)) begin
            nxt_st.irq = 1'b1;
            nxt_st.tout = !cur_ff.tout;
         end
      end else if (cur_ff.run == ST_IDLE && !is_one_shot) begin
         nxt_st.run = ST_RUN;
         nxt_st.wrapped = 1'b0;
         nxt_st.cnt = is_capture_mode ? '0 : reload_value;
         if (start_bhv && (op_mode == MODE_INTERVAL ||
             op_mode == MODE_CAPTURE)) begin
            nxt_st.irq = 1'b1;
            nxt_st.tout = !cur_ff.tout;
         end
      end else if (counting) begin
         if (is_capture_mode && capture_edge) begin
            // Capture: flag takes overflow history, not the wrap itself.
            nxt_st.cap = cur_ff.cnt;
            nxt_st.ovf = cur_ff.wrapped;
            nxt_st.wrapped = 1'b0;
            nxt_st.cnt = '0;
            nxt_st.irq = 1'b1;
            if (op_mode == MODE_CAP_ONE) begin
               nxt_st.run = ST_WAIT;
            end
         end else if (op_mode == MODE_EVENT) begin
            if (valid_edge) begin
               nxt_st.cnt = at_limit ? reload_value : cur_ff.cnt - 1'b1;
               nxt_st.irq = at_limit;
            end
         end else if (at_limit) begin
            if (is_capture_mode) begin
               nxt_st.wrapped = 1'b1;
               nxt_st.cnt = '0;
            end else begin
               nxt_st.irq = 1'b1;
               nxt_st.tout = !cur_ff.tout;
               nxt_st.cnt = reload_value;
               if (op_mode == MODE_ONE_COUNT) begin
                  nxt_st.run = ST_WAIT;
               end
            end
         end else begin
            // Direction follows the mode.
            nxt_st.cnt = count_up ? cur_ff.cnt + 1'b1 :
               cur_ff.cnt - 1'b1;
         end
      end
      // Judged on the mode being written, so no stale flag outlives it.
      if (!mode_counts_up(nxt_st.mode[MODE_MSB_POS:MODE_LSB_POS])) begin
         nxt_st.ovf = 1'b0;
      end
      // Status read: byte access only; others return zero and flag.
      nxt_st.rdata = '0;
      if (status_rd) begin
         if (status_rd_byte) begin
            nxt_st.rdata = {7'h00, cur_ff.ovf};
         end else begin
            nxt_st.rd_err = 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
         cur_ff.mode <= MODE_LOW_RESET;
         cur_ff.run <= ST_IDLE;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   // Outputs.
   assign count_up = mode_counts_up(op_mode);
   assign channel_mode_low_byte = cur_ff.mode;
   assign channel_overflow_status = STATUS_RESET | {7'h00, cur_ff.ovf};
   assign status_rdata = cur_ff.rdata;
   assign status_rd_err = cur_ff.rd_err;
   assign channel_counter = cur_ff.cnt;
   assign capture_value = cur_ff.cap;
   assign channel_interrupt = cur_ff.irq;
   assign channel_timer_output = cur_ff.tout;
   assign mode_illegal = !mode_legal(op_mode);

   AST_OVF_ONLY_CAPTURE: assert property (@(posedge clk_sys)
      disable iff (!rst_n) cur_ff.ovf |-> mode_counts_up(op_mode))
      else $error("overflow flag set outside capture modes");
   AST_OVF_ON_CAPTURE: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (is_capture_mode && $changed(cur_ff.ovf))
      |-> $past(counting && capture_edge && is_capture_mode))
      else $error("overflow flag changed without capture");
   AST_OVF_VALUE: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (counting && is_capture_mode && capture_edge
      && !count_stop && count_enable && !start_ev && !mode_wr)
      |=> cur_ff.ovf == $past(cur_ff.wrapped))
      else $error("overflow flag not taken from history");
   AST_NO_SW_IRQ: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (software_start_trigger && counting &&
      count_enable && !count_stop) |=> !channel_interrupt)
      else $error("interrupt on software restart");
   AST_ONE_COUNT_QUIET: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (op_mode == MODE_ONE_COUNT && start_ev &&
      !mode_wr && count_enable && !count_stop) |=> !channel_interrupt)
      else $error("one-count start raised interrupt");
   AST_DIR_UP: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (op_mode == MODE_CAPTURE) |-> count_up)
      else $error("capture mode not counting up");
   AST_DIR_DOWN: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (op_mode == MODE_INTERVAL ||
      op_mode == MODE_ONE_COUNT || op_mode == MODE_EVENT) |-> !count_up)
      else $error("down mode counting up");
   AST_MODE_BITS45: assert property (@(posedge clk_sys)
      disable iff (!rst_n) mode_wr |=> channel_mode_low_byte[5:4] == 2'h0)
      else $error("mode bits 4 or 5 set");
   AST_RD_WIDTH: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (status_rd && !status_rd_byte)
      |=> status_rd_err && status_rdata == 8'h00)
      else $error("non-byte status read answered");
   AST_NO_RETRIG: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (counting && op_mode == MODE_CAP_ONE &&
      !start_bhv && start_edge && !capture_edge &&
      !software_start_trigger) |-> !start_ev)
      else $error("retrigger accepted in capture one-count");
   AST_ONE_NO_RETRIG: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (counting && op_mode == MODE_ONE_COUNT &&
      !start_bhv && !software_start_trigger) |-> !start_ev)
      else $error("retrigger accepted in one-count");
   AST_ONE_RETRIG: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (counting && op_mode == MODE_ONE_COUNT &&
      start_bhv && start_edge && count_enable && !count_stop)
      |=> channel_counter == $past(reload_value) && !channel_interrupt)
      else $error("one-count retrigger not taken silently");
   AST_START_IRQ: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (cur_ff.run == ST_IDLE && count_enable &&
      !count_stop && !software_start_trigger && start_bhv &&
      op_mode == MODE_INTERVAL) |=> channel_interrupt)
      else $error("no interrupt at interval count start");
   AST_ONE_TOUT_QUIET: assert property (@(posedge clk_sys)
      disable iff (!rst_n) (op_mode == MODE_ONE_COUNT && start_ev &&
      !counting && count_enable && !count_stop)
      |=> $stable(channel_timer_output))
      else $error("one-count start changed timer output");
endmodule
`default_nettype wire

// File: tmr_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
// External pulse source that drives the channel's timer input pin.
module tmr_pin_src (
   input wire logic clk_sys,
   output logic pin
);
   // The pin idles low until the first pulse is requested.
   initial begin
      pin = 1'b0;
   end

   // Sets a level at a falling edge and keeps it for cyc clock cycles.
   task automatic hold(input logic lvl, input int cyc);
      pin = lvl;
      repeat (cyc) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

// File: tmr_chan_mode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
   checks_done++; \
   if ((a) !== (b)) begin \
      miscompares++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); \
   end \
end
module tmr_chan_mode_tb;
   import tmr_chan_pkg::*;
   localparam int W = 8;
   logic clk_sys, rst_n, pin, count_enable, software_start_trigger;
   logic mode_wr, status_rd, status_rd_byte, rd_pend, tmo;
   logic [W-1:0] reload_value, channel_counter, capture_value;
   logic [7:0] mode_wdata, channel_mode_low_byte, channel_overflow_status;
   logic [7:0] status_rdata, d;
   logic status_rd_err, count_up, channel_interrupt, channel_timer_output;
   logic mode_illegal;
   logic [8:0] exp_q[$];
   logic [8:0] cur_exp;
   int miscompares, checks_done, irq_cnt, i0, cycles, w, seed;

   tmr_pin_src src (.clk_sys(clk_sys), .pin(pin));

   tmr_chan_mode #(.WIDTH(W)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .channel_timer_input(pin),
      .count_enable(count_enable), .count_stop(1'b0),
      .software_start_trigger(software_start_trigger),
      .reload_value(reload_value), .mode_wr(mode_wr),
      .mode_wdata(mode_wdata), .status_rd(status_rd),
      .status_rd_byte(status_rd_byte),
      .channel_mode_low_byte(channel_mode_low_byte),
      .channel_overflow_status(channel_overflow_status),
      .status_rdata(status_rdata), .status_rd_err(status_rd_err),
      .channel_counter(channel_counter), .capture_value(capture_value),
      .count_up(count_up), .channel_interrupt(channel_interrupt),
      .channel_timer_output(channel_timer_output),
      .mode_illegal(mode_illegal));

   // Free-running system clock of 20 ns.
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Notes pending reads and cuts a hang short.
   always @(posedge clk_sys) begin
      rd_pend <= status_rd;
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // Counts interrupt pulses away from their launching edge, and compares
   // each answered read with the oldest noted expectation.
   always @(negedge clk_sys) begin
      if (channel_interrupt === 1'b1) irq_cnt++;
      if (rd_pend === 1'b1) begin
         cur_exp = exp_q.pop_front();
         `CHK({status_rd_err, status_rdata}, cur_exp)
      end
   end

   task automatic tally_and_finish();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Writes the mode byte with the channel held idle.
   task automatic wr_mode(input logic [7:0] v);
      count_enable = 1'b0;
      mode_wdata = v;
      mode_wr = 1'b1;
      step(1);
      mode_wr = 1'b0;
      step(1);
   endtask

   // Issues a status read and notes the expected error bit and data.
   task automatic rd(input logic byte_acc, input logic [8:0] e);
      exp_q.push_back(e);
      status_rd_byte = byte_acc;
      status_rd = 1'b1;
      step(1);
      status_rd = 1'b0;
      step(1);
   endtask

   // Ends a measured level and waits for the capture interrupt.
   task automatic capture_end(input logic lvl);
      i0 = irq_cnt;
      src.hold(lvl, 1);
      for (int k = 0; k < 10 && irq_cnt == i0; k++) step(1);
      `CHK(irq_cnt != i0, 1'b1)
   endtask

   initial begin
      rst_n = 1'b0;
      count_enable = 1'b0;
      software_start_trigger = 1'b0;
      mode_wr = 1'b0;
      mode_wdata = 8'h00;
      status_rd = 1'b0;
      status_rd_byte = 1'b1;
      seed = 67233;
      reload_value = 8'h40 | 8'($random(seed));
      step(12);
      rst_n = 1'b1;
      step(1);
      `CHK(channel_mode_low_byte, MODE_LOW_RESET)
      `CHK(channel_overflow_status, STATUS_RESET)
      rd(1'b1, 9'h000);
      rd(1'b0, 9'h100);
      // Every mode code, with random edge and start bits.
      for (int m = 0; m < 8; m++) begin
         d = 8'($random(seed)) & 8'hc1 | 8'(m << 1);
         wr_mode(d);
         `CHK(channel_mode_low_byte, d)
         `CHK(mode_illegal, m == 1 || m == 5 || m == 7)
         if (!(m == 1 || m == 5 || m == 7)) begin
            `CHK(count_up, m == 2 || m == 6)
         end
      end
      // Interval mode with the start bit set pulses at count start.
      wr_mode(8'h01);
      d[0] = channel_timer_output;
      i0 = irq_cnt;
      count_enable = 1'b1;
      step(4);
      `CHK(irq_cnt - i0, 1)
      `CHK(channel_timer_output, ~d[0])
      // A software start reloads the counter silently.
      step(20);
      i0 = irq_cnt;
      software_start_trigger = 1'b1;
      step(1);
      software_start_trigger = 1'b0;
      step(2);
      `CHK(irq_cnt, i0)
      `CHK(reload_value - channel_counter <= 3, 1'b1)
      step(300);
      rd(1'b1, 9'h000);
      // One-count mode started by a rising pin edge stays silent.
      wr_mode(8'h48);
      count_enable = 1'b1;
      i0 = irq_cnt;
      src.hold(1'b1, 10);
      `CHK(irq_cnt, i0)
      w = reload_value - channel_counter;
      `CHK(w >= 3 && w <= 9, 1'b1)
      src.hold(1'b0, 4);
      // High width measurement, short pulse without overflow.
      wr_mode(8'hcc);
      count_enable = 1'b1;
      w = 8 + ($random(seed) & 15);
      src.hold(1'b1, w);
      capture_end(1'b0);
      `CHK(capture_value >= w - 2 && capture_value <= w + 2, 1'b1)
      rd(1'b1, 9'h000);
      // Long pulse wraps the counter; flag waits for the capture.
      step(4);
      src.hold(1'b1, 270);
      rd(1'b1, 9'h000);
      src.hold(1'b1, 30);
      capture_end(1'b0);
      rd(1'b1, 9'h001);
      `CHK(channel_overflow_status, 8'h01)
      step(4);
      src.hold(1'b1, w);
      capture_end(1'b0);
      rd(1'b1, 9'h000);
      // Low width measurement with a random width.
      src.hold(1'b1, 6);
      wr_mode(8'h8c);
      count_enable = 1'b1;
      step(2);
      w = 8 + ($random(seed) & 15);
      src.hold(1'b0, w);
      capture_end(1'b1);
      `CHK(capture_value >= w - 2 && capture_value <= w + 2, 1'b1)
      step(4);
      tally_and_finish();
   end
endmodule
`default_nettype wire
